// ### pkg/cmt_defs.vh
// Register offsets, field positions and reset values for the compare-match timer
`ifndef CMT_DEFS_VH
`define CMT_DEFS_VH

// Register byte addresses
`define CMT_ADDR_UNIT_ENABLE     8'h00
`define CMT_ADDR_PRESCALER0      8'h04
`define CMT_ADDR_CLK_BUS_SRC     8'h08
`define CMT_ADDR_RUN_CTRL        8'h0c
`define CMT_ADDR_IRQ_STATUS      8'h10
`define CMT_ADDR_IRQ_CLEAR       8'h14
`define CMT_ADDR_IRQ_ENABLE      8'h18
`define CMT_ADDR_SUB0_MODE       8'h20
`define CMT_ADDR_SUB0_IO         8'h24
`define CMT_ADDR_SUB0_IRQ_EN     8'h28
`define CMT_ADDR_SUB0_STATUS     8'h2c
`define CMT_ADDR_SUB0_STAT_CLR   8'h30
`define CMT_ADDR_SUB0_COMPARE    8'h34
`define CMT_ADDR_SUB0_COUNTER    8'h38
`define CMT_ADDR_SUB1_MODE       8'h40
`define CMT_ADDR_SUB1_IO         8'h44
`define CMT_ADDR_SUB1_IRQ_EN     8'h48
`define CMT_ADDR_SUB1_STATUS     8'h4c
`define CMT_ADDR_SUB1_STAT_CLR   8'h50
`define CMT_ADDR_SUB1_COMPARE    8'h54
`define CMT_ADDR_SUB1_COUNTER    8'h58

// Field positions
`define CMT_UEN_TIMER_BIT        3
`define CMT_UEN_PRESC_BIT        0
`define CMT_CBS_BUS4_RISE_BIT    4
`define CMT_CBS_BUS4_FALL_BIT    5
`define CMT_MODE_PWM_BIT         3
`define CMT_MODE_CLKBUS4_BIT     2
`define CMT_IO_TOGGLE_VAL        4'h3
`define CMT_MATCH_BIT            0

// Reset values
`define CMT_RST_PRESCALER        16'h0000
`define CMT_RST_COMPARE          32'hffffffff

`endif

// ### hdl/cmt_sync2.v
// Two-flop synchroniser for the external event pin
`timescale 1ns/1ps
module cmt_sync2 (
  input  wire clk,
  input  wire rst,
  input  wire d,
  output wire q
);
  reg s1_ff;
  reg s2_ff;

  // Only the second flop feeds logic
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
    end
  end

  assign q = s2_ff;
endmodule // cmt_sync2

// ### hdl/cmt_sub.v
// One timer subblock: counter, compare, toggle output and match output
`timescale 1ns/1ps
`include "cmt_defs.vh"
module cmt_sub #(
  parameter W = 32
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         tick,
  input  wire         pwm_mode,
  input  wire         toggle_en,
  input  wire [W-1:0] compare,
  input  wire         cnt_wr,
  input  wire [W-1:0] cnt_wdata,
  output reg  [W-1:0] count_ff,
  output reg          out_ff,
  output wire         match
);
  reg [W-1:0] nxt_count;

  // Match seen only on an advancing tick
  assign match = tick && (count_ff == compare);

  // Next count: software write, PWM clear or increment
  always @* begin
    nxt_count = count_ff;
    if (cnt_wr)
      nxt_count = cnt_wdata;
    else if (match && pwm_mode)
      nxt_count = {W{1'b0}};
    else if (tick)
      nxt_count = count_ff + {{(W-1){1'b0}}, 1'b1};
  end

  // Counter and toggled output
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count_ff <= {W{1'b0}};
      out_ff   <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      if (match && toggle_en)
        out_ff <= ~out_ff;
    end
  end
endmodule // cmt_sub

// ### hdl/cmt_top.v
// Compare-match timer with two subblocks, prescaler and clock bus
//
// Contract
// - Subblock 1 pin inverts on each counter/compare match when toggle selected.
// - PWM mode clears counter to zero on match, then counts up again.
// - Output control value 0x3 selects toggle on compare match.
// - Match sets the subblock status flag; it holds until software clears.
// - Writing 0x1 to status-clear clears the flag; software clears before next match.
// - Interrupt enable 0x1 makes each match raise an interrupt request.
// - Run control holds one count-enable bit per subblock.
// - Clock bus source 0x10 drives clock bus 4 from event input rising edges.
// - Mode 0xC on subblock 1 selects PWM and clock bus 4 as count clock.
// - Mode 0x8 on subblock 0 selects PWM with prescaler clock.
// - Prescaler 0 divides the clock by programmed value plus one.
// - Unit enable 0x09 enables timer and prescaler; counters stop otherwise (here a clock bus 4 subblock still counts under 0x08).
// - Without PWM the counter free-runs; software adds increments to compare.
// - Subblock 1 counts events, interrupts after n; software divides subblock 0 count.
// - Subblock 0 counter is writable; writing zero restarts measurement.
// - Subblock 1 compare holds the event count at which it matches.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "cmt_defs.vh"
module cmt_top #(
  parameter CW = 32,
  parameter PW = 16
) (
  input  wire          clk,
  input  wire          rst,
  input  wire [7:0]    addr,
  input  wire [31:0]   wdata,
  input  wire          wr,
  input  wire          rd,
  output reg  [31:0]   rdata,
  input  wire          ext_event_clock_in,
  output reg           sub0_compare_out,
  output reg           sub1_compare_out,
  output reg           sub0_match_irq,
  output reg           sub1_match_irq,
  output reg           irq
);
  // Control registers
  reg [7:0]    unit_enable_ff;
  reg [PW-1:0] prescaler0_divider_ff;
  reg [7:0]    clock_bus_source_ctrl_ff;
  reg [1:0]    subblock_run_ctrl_ff;
  reg [15:0]   sub0_mode_ctrl_ff;
  reg [15:0]   sub1_mode_ctrl_ff;
  reg [15:0]   sub0_io_ctrl_ff;
  reg [15:0]   sub1_io_ctrl_ff;
  reg          sub0_irq_enable_ff;
  reg          sub1_irq_enable_ff;
  reg [CW-1:0] sub0_compare_reg_ff;
  reg [CW-1:0] sub1_compare_reg_ff;
  reg          sub0_flag_ff;
  reg          sub1_flag_ff;
  reg [1:0]    irq_stat_ff;
  reg [1:0]    irq_en_ff;
  reg [PW-1:0] presc_cnt_ff;
  reg          presc_tick_ff;
  reg          ev_prev_ff;
  reg          bus4_tick_ff;
  reg [31:0]   nxt_rdata;

  wire          ev_sync;
  wire [CW-1:0] sub0_count;
  wire [CW-1:0] sub1_count;
  wire          sub0_out;
  wire          sub1_out;
  wire          sub0_match;
  wire          sub1_match;
  wire          timer_en;
  wire          presc_en;
  wire [1:0]    sub_clkbus4;
  wire [1:0]    sub_pwm;
  wire [1:0]    sub_toggle;
  wire [1:0]    sub_cnt_wr;
  wire [1:0]    sub_tick;
  wire [1:0]    sub_out;
  wire [1:0]    sub_match;
  wire [CW-1:0] sub_cmp [0:1];
  wire [CW-1:0] sub_cnt [0:1];

  // Event pin synchronised before any use
  cmt_sync2 u_sync (
    .clk (clk),
    .rst (rst),
    .d   (ext_event_clock_in),
    .q   (ev_sync)
  );

  // Unit enables
  assign timer_en = unit_enable_ff[`CMT_UEN_TIMER_BIT];
  assign presc_en = unit_enable_ff[`CMT_UEN_PRESC_BIT];

  // Prescaler 0: one tick every divider+1 clocks
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      presc_cnt_ff  <= {PW{1'b0}};
      presc_tick_ff <= 1'b0;
    end else if (!presc_en) begin
      presc_cnt_ff  <= {PW{1'b0}};
      presc_tick_ff <= 1'b0;
    end else if (presc_cnt_ff >= prescaler0_divider_ff) begin
      presc_cnt_ff  <= {PW{1'b0}};
      presc_tick_ff <= 1'b1;
    end else begin
      presc_cnt_ff  <= presc_cnt_ff + {{(PW-1){1'b0}}, 1'b1};
      presc_tick_ff <= 1'b0;
    end
  end

  // Clock bus 4 from chosen edges of the event input
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_prev_ff   <= 1'b0;
      bus4_tick_ff <= 1'b0;
    end else begin
      ev_prev_ff   <= ev_sync;
      bus4_tick_ff <= (clock_bus_source_ctrl_ff[`CMT_CBS_BUS4_RISE_BIT] && ev_sync && !ev_prev_ff)
                   || (clock_bus_source_ctrl_ff[`CMT_CBS_BUS4_FALL_BIT] && !ev_sync && ev_prev_ff);
    end
  end

  // Clock bus 4 or prescaler 0 as count clock, per subblock
  assign sub_clkbus4 = {sub1_mode_ctrl_ff[`CMT_MODE_CLKBUS4_BIT],
                        sub0_mode_ctrl_ff[`CMT_MODE_CLKBUS4_BIT]};

  // Counter clear on match, per subblock
  assign sub_pwm = {sub1_mode_ctrl_ff[`CMT_MODE_PWM_BIT],
                    sub0_mode_ctrl_ff[`CMT_MODE_PWM_BIT]};

  // Toggle on match when the output control nibble selects it
  assign sub_toggle = {sub1_io_ctrl_ff[3:0] == `CMT_IO_TOGGLE_VAL,
                       sub0_io_ctrl_ff[3:0] == `CMT_IO_TOGGLE_VAL};

  // Software counter writes, one strobe per subblock
  assign sub_cnt_wr = {wr && (addr == `CMT_ADDR_SUB1_COUNTER),
                       wr && (addr == `CMT_ADDR_SUB0_COUNTER)};

  // Compare values: sub0 time base, sub1 event count
  assign sub_cmp[0] = sub0_compare_reg_ff;
  assign sub_cmp[1] = sub1_compare_reg_ff;

  // One counter per subblock, gated by unit enable and its run bit
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sub
      // Count clock select and run gating
      assign sub_tick[g] = timer_en && subblock_run_ctrl_ff[g] &&
                           (sub_clkbus4[g] ? bus4_tick_ff : presc_tick_ff);

      // Counter, compare and toggled output
      cmt_sub #(
        .W (CW)
      ) u_sub (
        .clk       (clk),
        .rst       (rst),
        .tick      (sub_tick[g]),
        .pwm_mode  (sub_pwm[g]),
        .toggle_en (sub_toggle[g]),
        .compare   (sub_cmp[g]),
        .cnt_wr    (sub_cnt_wr[g]),
        .cnt_wdata (wdata[CW-1:0]),
        .count_ff  (sub_cnt[g]),
        .out_ff    (sub_out[g]),
        .match     (sub_match[g])
      );
    end
  endgenerate

  // Named views of the per-subblock results
  assign sub0_count = sub_cnt[0];
  assign sub1_count = sub_cnt[1];
  assign sub0_out   = sub_out[0];
  assign sub1_out   = sub_out[1];
  assign sub0_match = sub_match[0];
  assign sub1_match = sub_match[1];

  // Register writes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      unit_enable_ff           <= 8'h00;
      prescaler0_divider_ff    <= `CMT_RST_PRESCALER;
      clock_bus_source_ctrl_ff <= 8'h00;
      subblock_run_ctrl_ff     <= 2'h0;
      sub0_mode_ctrl_ff        <= 16'h0000;
      sub1_mode_ctrl_ff        <= 16'h0000;
      sub0_io_ctrl_ff          <= 16'h0000;
      sub1_io_ctrl_ff          <= 16'h0000;
      sub0_irq_enable_ff       <= 1'b0;
      sub1_irq_enable_ff       <= 1'b0;
      sub0_compare_reg_ff      <= `CMT_RST_COMPARE;
      sub1_compare_reg_ff      <= `CMT_RST_COMPARE;
      irq_en_ff                <= 2'h0;
    end else if (wr) begin
      // Common controls first, then the subblock registers
      if (addr == `CMT_ADDR_UNIT_ENABLE)
        unit_enable_ff <= wdata[7:0];
      else if (addr == `CMT_ADDR_PRESCALER0)
        prescaler0_divider_ff <= wdata[PW-1:0];
      else if (addr == `CMT_ADDR_CLK_BUS_SRC)
        clock_bus_source_ctrl_ff <= wdata[7:0];
      else if (addr == `CMT_ADDR_RUN_CTRL)
        subblock_run_ctrl_ff <= wdata[1:0];
      else if (addr == `CMT_ADDR_IRQ_ENABLE)
        irq_en_ff <= wdata[1:0];
      else if (addr == `CMT_ADDR_SUB0_MODE)
        sub0_mode_ctrl_ff <= wdata[15:0];
      else if (addr == `CMT_ADDR_SUB1_MODE)
        sub1_mode_ctrl_ff <= wdata[15:0];
      else if (addr == `CMT_ADDR_SUB0_IO)
        sub0_io_ctrl_ff <= wdata[15:0];
      else if (addr == `CMT_ADDR_SUB1_IO)
        sub1_io_ctrl_ff <= wdata[15:0];
      else if (addr == `CMT_ADDR_SUB0_IRQ_EN)
        sub0_irq_enable_ff <= wdata[`CMT_MATCH_BIT];
      else if (addr == `CMT_ADDR_SUB1_IRQ_EN)
        sub1_irq_enable_ff <= wdata[`CMT_MATCH_BIT];
      else if (addr == `CMT_ADDR_SUB0_COMPARE)
        sub0_compare_reg_ff <= wdata[CW-1:0];
      else if (addr == `CMT_ADDR_SUB1_COMPARE)
        sub1_compare_reg_ff <= wdata[CW-1:0];
    end
  end

  // Match flags: set wins over a same-cycle clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sub0_flag_ff <= 1'b0;
      sub1_flag_ff <= 1'b0;
    end else begin
      if (sub0_match)
        sub0_flag_ff <= 1'b1;
      else if (wr && addr == `CMT_ADDR_SUB0_STAT_CLR && wdata[`CMT_MATCH_BIT])
        sub0_flag_ff <= 1'b0;
      if (sub1_match)
        sub1_flag_ff <= 1'b1;
      else if (wr && addr == `CMT_ADDR_SUB1_STAT_CLR && wdata[`CMT_MATCH_BIT])
        sub1_flag_ff <= 1'b0;
    end
  end

  // Common sticky interrupt status with write-one clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_ff <= 2'h0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~((wr && addr == `CMT_ADDR_IRQ_CLEAR) ? wdata[1:0] : 2'h0))
                   | {sub1_match, sub0_match};
    end
  end

  // Read mux
  always @* begin
    nxt_rdata = 32'h00000000;
    // Narrow registers read in the low bits, upper bits zero
    if (addr == `CMT_ADDR_UNIT_ENABLE)
      nxt_rdata[7:0] = unit_enable_ff;
    else if (addr == `CMT_ADDR_PRESCALER0)
      nxt_rdata[PW-1:0] = prescaler0_divider_ff;
    else if (addr == `CMT_ADDR_CLK_BUS_SRC)
      nxt_rdata[7:0] = clock_bus_source_ctrl_ff;
    else if (addr == `CMT_ADDR_RUN_CTRL)
      nxt_rdata[1:0] = subblock_run_ctrl_ff;
    else if (addr == `CMT_ADDR_IRQ_STATUS)
      nxt_rdata[1:0] = irq_stat_ff;
    else if (addr == `CMT_ADDR_IRQ_ENABLE)
      nxt_rdata[1:0] = irq_en_ff;
    else if (addr == `CMT_ADDR_SUB0_MODE)
      nxt_rdata[15:0] = sub0_mode_ctrl_ff;
    else if (addr == `CMT_ADDR_SUB1_MODE)
      nxt_rdata[15:0] = sub1_mode_ctrl_ff;
    else if (addr == `CMT_ADDR_SUB0_IO)
      nxt_rdata[15:0] = sub0_io_ctrl_ff;
    else if (addr == `CMT_ADDR_SUB1_IO)
      nxt_rdata[15:0] = sub1_io_ctrl_ff;
    else if (addr == `CMT_ADDR_SUB0_IRQ_EN)
      nxt_rdata[0] = sub0_irq_enable_ff;
    else if (addr == `CMT_ADDR_SUB1_IRQ_EN)
      nxt_rdata[0] = sub1_irq_enable_ff;
    else if (addr == `CMT_ADDR_SUB0_STATUS)
      nxt_rdata[0] = sub0_flag_ff;
    else if (addr == `CMT_ADDR_SUB1_STATUS)
      nxt_rdata[0] = sub1_flag_ff;
    else if (addr == `CMT_ADDR_SUB0_COMPARE)
      nxt_rdata[CW-1:0] = sub0_compare_reg_ff;
    else if (addr == `CMT_ADDR_SUB1_COMPARE)
      nxt_rdata[CW-1:0] = sub1_compare_reg_ff;
    else if (addr == `CMT_ADDR_SUB0_COUNTER)
      nxt_rdata[CW-1:0] = sub0_count;
    else if (addr == `CMT_ADDR_SUB1_COUNTER)
      nxt_rdata[CW-1:0] = sub1_count;
  end

  // Read data valid the cycle after the strobe only
  always @(posedge clk or posedge rst) begin
    if (rst)
      rdata <= 32'h00000000;
    else if (rd)
      rdata <= nxt_rdata;
    else
      rdata <= 32'h00000000;
  end

  // Registered outputs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sub0_compare_out <= 1'b0;
      sub1_compare_out <= 1'b0;
      sub0_match_irq   <= 1'b0;
      sub1_match_irq   <= 1'b0;
      irq              <= 1'b0;
    end else begin
      sub0_compare_out <= sub0_out;
      sub1_compare_out <= sub1_out;
      sub0_match_irq   <= sub0_flag_ff && sub0_irq_enable_ff;
      sub1_match_irq   <= sub1_flag_ff && sub1_irq_enable_ff;
      irq              <= |(irq_stat_ff & irq_en_ff);
    end
  end
endmodule // cmt_top

// ### verif/cmt_top_properties.sv
// Port checker for the compare-match timer
`timescale 1ns/1ps
`include "cmt_defs.vh"
module cmt_top_properties (
  input wire        clk,
  input wire        rst,
  input wire [7:0]  addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [31:0] rdata,
  input wire        sub0_compare_out,
  input wire        sub1_compare_out,
  input wire        sub0_match_irq,
  input wire        sub1_match_irq,
  input wire        irq
);
  reg       en0_ff, en1_ff, uen_ff;
  reg [1:0] run_ff;
  // Writes that may drop the subblock 0 request, plus the common status clear
  wire clr0 = wr && addr == `CMT_ADDR_SUB0_STAT_CLR && wdata[0];
  wire hit0 = wr && (addr == `CMT_ADDR_SUB0_STAT_CLR || addr == `CMT_ADDR_SUB0_IRQ_EN
              || addr == `CMT_ADDR_IRQ_CLEAR);
  wire g0   = uen_ff && run_ff[0];
  wire g1   = uen_ff && run_ff[1];
  // Shadow copies of enables written over the bus
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      en0_ff <= 1'b0;
      en1_ff <= 1'b0;
      uen_ff <= 1'b0;
      run_ff <= 2'h0;
    end else if (wr) begin
      if (addr == `CMT_ADDR_SUB0_IRQ_EN) en0_ff <= wdata[0];
      if (addr == `CMT_ADDR_SUB1_IRQ_EN) en1_ff <= wdata[0];
      if (addr == `CMT_ADDR_UNIT_ENABLE) uen_ff <= wdata[`CMT_UEN_TIMER_BIT];
      if (addr == `CMT_ADDR_RUN_CTRL) run_ff <= wdata[1:0];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_rd_idle; !rd |=> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_en_back;
    rd && addr == `CMT_ADDR_SUB0_IRQ_EN |=> rdata == {31'h0, en0_ff};
  endproperty
  a_en_back: assert property (p_en_back) else $error("enable readback wrong");
  property p_irq0_set; $changed(sub0_compare_out) && en0_ff |=> sub0_match_irq; endproperty
  a_irq0_set: assert property (p_irq0_set) else $error("no sub0 request");
  property p_irq1_set; $changed(sub1_compare_out) && en1_ff |=> sub1_match_irq; endproperty
  a_irq1_set: assert property (p_irq1_set) else $error("no sub1 request");
  property p_irq0_hold; sub0_match_irq && !hit0 && !$past(hit0) |=> sub0_match_irq; endproperty
  a_irq0_hold: assert property (p_irq0_hold) else $error("sub0 flag lost");
  property p_irq0_clr; clr0 ##2 $stable(sub0_compare_out) |-> !sub0_match_irq; endproperty
  a_irq0_clr: assert property (p_irq0_clr) else $error("sub0 clear ignored");
  property p_stop0; !g0 [*3] |-> $stable(sub0_compare_out); endproperty
  a_stop0: assert property (p_stop0) else $error("sub0 ran while stopped");
  property p_stop1; !g1 [*3] |-> $stable(sub1_compare_out); endproperty
  a_stop1: assert property (p_stop1) else $error("sub1 ran while stopped");
  c_tog0: cover property ($changed(sub0_compare_out));
  c_irq1: cover property ($rose(sub1_match_irq));
  c_irq: cover property ($rose(irq));
endmodule // cmt_top_properties

bind cmt_top cmt_top_properties u_props (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .sub0_compare_out(sub0_compare_out),
  .sub1_compare_out(sub1_compare_out), .sub0_match_irq(sub0_match_irq),
  .sub1_match_irq(sub1_match_irq), .irq(irq));

// ### verif/cmt_evt_src.sv
// Event source driving the external event pin
`timescale 1ns/1ps
module cmt_evt_src (
  input  wire        clk,
  input  wire        go,
  input  wire [15:0] npl,
  output reg         pin,
  output wire        busy
);
  reg [15:0] left_ff;
  reg        ph_ff;
  assign busy = left_ff != 16'h0;
  initial begin
    pin = 1'b0;
    left_ff = 16'h0;
    ph_ff = 1'b0;
  end
  // Two clocks low, two high per event; pin rests low
  always @(posedge clk) begin
    if (go) begin
      left_ff <= npl;
    end else if (busy) begin
      ph_ff <= ~ph_ff;
      if (ph_ff) begin
        pin <= ~pin;
        if (pin) left_ff <= left_ff - 16'h1;
      end
    end
  end
endmodule // cmt_evt_src

// ### verif/cmt_top_tb.sv
// Self-checking bench for the compare-match timer
`timescale 1ns/1ps
`include "cmt_defs.vh"
module cmt_top_tb;
  reg         clk, rst, wr, rd, go;
  reg  [7:0]  addr;
  reg  [31:0] wdata, d;
  reg  [15:0] npl;
  wire [31:0] rdata;
  wire        pin, busy, o0, o1, i0, i1, irq;
  integer     fails, n_compared, cyc, n, k, t0;
  cmt_top DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ext_event_clock_in(pin), .sub0_compare_out(o0), .sub1_compare_out(o1),
    .sub0_match_irq(i0), .sub1_match_irq(i1), .irq(irq));
  cmt_evt_src u_src (.clk(clk), .go(go), .npl(npl), .pin(pin), .busy(busy));
  // Clock at 125 MHz
  initial clk = 1'b0;
  always #4 clk = ~clk;
  task summarize;
    begin
      $display("Compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One write strobe cycle
  task wreg(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  // Read strobe, data taken in the next cycle
  task rreg(input [7:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
    end
  endtask
  function sel(input integer s);
    sel = s == 0 ? o0 : s == 1 ? i0 : s == 2 ? i1 : busy;
  endfunction
  // Bounded wait for a level, clocks counted in n
  task wait_on(input integer s, input lvl);
    begin
      n = 0;
      while (sel(s) !== lvl && n < 8000) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      chk(n < 8000, 1'b1);
    end
  endtask
  task pulse(input [15:0] p);
    begin
      @(posedge clk);
      npl <= p;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      #1;
    end
  endtask
  task t_regs;
    begin
      rreg(`CMT_ADDR_SUB1_COMPARE);
      chk(d, `CMT_RST_COMPARE);
      wreg(`CMT_ADDR_SUB0_STATUS, 32'h1);
      rreg(`CMT_ADDR_SUB0_STATUS);
      chk(d, 32'h0);
      rreg(8'hfc);
      chk(d, 32'h0);
      wreg(`CMT_ADDR_SUB0_COUNTER, 32'h1234);
      rreg(`CMT_ADDR_SUB0_COUNTER);
      chk(d, 32'h1234);
    end
  endtask
  task t_pwm;
    begin
      wreg(`CMT_ADDR_PRESCALER0, 32'h9);
      wreg(`CMT_ADDR_SUB0_MODE, 32'h8);
      wreg(`CMT_ADDR_SUB0_IO, 32'h3);
      wreg(`CMT_ADDR_SUB0_COMPARE, 32'h4);
      wreg(`CMT_ADDR_SUB0_COUNTER, 32'h0);
      wreg(`CMT_ADDR_RUN_CTRL, 32'h1);
      wreg(`CMT_ADDR_UNIT_ENABLE, 32'h9);
      wait_on(0, ~o0);
      for (k = 0; k < 2; k = k + 1) begin
        wait_on(0, ~o0);
        chk(n, 50);
      end
      wreg(`CMT_ADDR_UNIT_ENABLE, 32'h0);
      k = o0;
      repeat (120) @(posedge clk);
      chk(o0, k);
      wreg(`CMT_ADDR_RUN_CTRL, 32'h0);
      wreg(`CMT_ADDR_UNIT_ENABLE, 32'h9);
      repeat (120) @(posedge clk);
      chk(o0, k);
    end
  endtask
  task t_add;
    begin
      wreg(`CMT_ADDR_SUB0_MODE, 32'h0);
      wreg(`CMT_ADDR_PRESCALER0, 32'h0);
      wreg(`CMT_ADDR_SUB0_COMPARE, 32'h50);
      wreg(`CMT_ADDR_SUB0_IRQ_EN, 32'h1);
      rreg(`CMT_ADDR_SUB0_IRQ_EN);
      chk(d, 32'h1);
      wreg(`CMT_ADDR_SUB0_STAT_CLR, 32'h1);
      wreg(`CMT_ADDR_IRQ_CLEAR, 32'h3);
      wreg(`CMT_ADDR_IRQ_ENABLE, 32'h1);
      wreg(`CMT_ADDR_SUB0_COUNTER, 32'h0);
      wreg(`CMT_ADDR_RUN_CTRL, 32'h1);
      for (k = 0; k < 3; k = k + 1) begin
        wait_on(1, 1'b1);
        if (k > 0) chk(cyc - t0, 80);
        t0 = cyc;
        rreg(`CMT_ADDR_SUB0_STATUS);
        chk(d, 32'h1);
        chk(irq, 1'b1);
        wreg(`CMT_ADDR_IRQ_ENABLE, 32'h0);
        wreg(`CMT_ADDR_SUB0_STAT_CLR, 32'h1);
        chk(irq, 1'b0);
        wreg(`CMT_ADDR_IRQ_CLEAR, 32'h3);
        chk(i0, 1'b0);
        wreg(`CMT_ADDR_IRQ_ENABLE, 32'h1);
        wreg(`CMT_ADDR_SUB0_COMPARE, 32'h50 * (k + 2));
      end
      wreg(`CMT_ADDR_RUN_CTRL, 32'h0);
    end
  endtask
  task t_evt;
    begin
      wreg(`CMT_ADDR_CLK_BUS_SRC, 32'h10);
      wreg(`CMT_ADDR_SUB1_MODE, 32'hc);
      wreg(`CMT_ADDR_SUB1_IO, 32'h3);
      wreg(`CMT_ADDR_SUB1_IRQ_EN, 32'h1);
      wreg(`CMT_ADDR_SUB1_COMPARE, 32'h500);
      wreg(`CMT_ADDR_PRESCALER0, 32'h9);
      wreg(`CMT_ADDR_SUB0_COMPARE, 32'hffffffff);
      wreg(`CMT_ADDR_RUN_CTRL, 32'h3);
      wreg(`CMT_ADDR_SUB0_COUNTER, 32'h0);
      t0 = cyc;
      pulse(16'h500);
      wait_on(3, 1'b0);
      repeat (8) @(posedge clk);
      chk({o1, i1}, 2'b00);
      pulse(16'h1);
      wait_on(2, 1'b1);
      chk(o1, 1'b1);
      k = (cyc - t0) / 10;
      rreg(`CMT_ADDR_SUB0_COUNTER);
      chk(d >= k - 2 && d <= k + 2, 1'b1);
      wreg(`CMT_ADDR_CLK_BUS_SRC, 32'h20);
      pulse(16'h3);
      wait_on(3, 1'b0);
      repeat (8) @(posedge clk);
      rreg(`CMT_ADDR_SUB1_COUNTER);
      chk(d, 32'h3);
    end
  endtask
  // Cycle count and hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      $display("ERROR %0t: timeout", $time);
      summarize;
    end
  end
  // Reset, then the scenarios in turn
  initial begin
    {rst, wr, rd, go} = 4'b1000;
    addr = 8'h0;
    wdata = 32'h0;
    npl = 16'h0;
    fails = 0;
    n_compared = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_pwm;
    t_add;
    t_evt;
    summarize;
  end
endmodule // cmt_top_tb
